// [hdl/tuning_regs_pkg.sv]
package tuning_regs_pkg;

	// ==========================================================
	// Register bus geometry.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// ==========================================================
	// Register offsets.
	localparam logic [11:0] CHAN_B_DITHER_CTRL_OFS = 12'h434;
	localparam logic [11:0] CHAN_B_SPECIAL_PERF_OFS = 12'h439;
	localparam logic [11:0] HIGH_IF_PART_THREE_OFS = 12'h51d;
	localparam logic [11:0] CHAN_C_CHOPPER_CTRL_OFS = 12'h522;
	localparam logic [11:0] CHAN_C_DITHER_CTRL_OFS = 12'h534;
	localparam logic [11:0] CHAN_C_SPECIAL_PERF_OFS = 12'h539;
	localparam logic [11:0] HIGH_IF_UPPER_PAIR_OFS = 12'h608;

	// ==========================================================
	// Readable field masks; all other bits are write-only and read as zero.
	localparam logic [7:0] DITHER_MASK = 8'h28;
	localparam logic [7:0] BEST_PERF_MASK = 8'h08;
	localparam logic [7:0] HIGH_IF3_MASK = 8'h02;
	localparam logic [7:0] CHOPPER_MASK = 8'h02;
	localparam logic [7:0] HIGH_IF_UPPER_MASK = 8'hc0;

	// ==========================================================
	// Field positions.
	localparam int DITH_HI_BIT = 5;
	localparam int DITH_LO_BIT = 3;
	localparam int BEST_PERF_BIT = 3;
	localparam int HIGH_IF3_BIT = 1;
	localparam int CHOPPER_BIT = 1;
	localparam int HIGH_IF_UPPER_HI_BIT = 7;
	localparam int HIGH_IF_UPPER_LO_BIT = 6;

	// ==========================================================
	// Reset value of every register.
	localparam logic [7:0] REG_RESET = 8'h00;

endpackage

// [hdl/adc_channel_tuning_regs.sv]
`timescale 1ns/10ps
module adc_channel_tuning_regs (
	input wire logic sys_clk_i, // System clock, 20 MHz.
	input wire logic rstn_i, // Asynchronous reset, active low.
	input wire logic [11:0] addr_i, // Register address.
	input wire logic [7:0] wdata_i, // Write data.
	input wire logic wr_i, // Write strobe.
	input wire logic rd_i, // Read strobe.
	output logic [7:0] rdata_o, // Read data, valid the cycle after rd_i.
	input wire logic [1:0] chan_b_companion_i, // Channel B dither bits held elsewhere.
	input wire logic [1:0] chan_c_companion_i, // Channel C dither bits held elsewhere.
	output logic chan_b_no_dither_o, // High when channel B dither is off.
	output logic chan_c_no_dither_o, // High when channel C dither is off.
	output logic chan_b_best_perf_o, // Channel B best-performance mode.
	output logic chan_c_best_perf_o, // Channel C best-performance mode.
	output logic chan_c_no_chopper_o, // High when channel C chopper is disabled.
	output logic high_freq_input_part3_o, // High-IF mode bit, part three.
	output logic [1:0] high_freq_input_upper_o // Upper high-IF mode pair.
);

	// ==========================================================
	// Helper functions

	// Tells whether the bus address names the given register offset.
	// The match is exact on all twelve bits, so neighbouring offsets never alias.
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Tells whether both bits of a dither pair are set.
	// A single bit on its own is not a valid request and keeps dither running.
	function automatic logic pair_set(input logic [7:0] val);
		pair_set = val[tuning_regs_pkg::DITH_HI_BIT] & val[tuning_regs_pkg::DITH_LO_BIT];
	endfunction

	// ==========================================================
	// Write decode

	// One write enable per register, so each store below only looks at its own strobe.
	logic wr_b_dither;
	logic wr_b_perf;
	logic wr_part3;
	logic wr_chopper;
	logic wr_c_dither;
	logic wr_c_perf;
	logic wr_upper;

	// A write lands only on an exact offset; writes to unmapped offsets are ignored.
	assign wr_b_dither = wr_i
		& hit(addr_i, tuning_regs_pkg::CHAN_B_DITHER_CTRL_OFS);
	assign wr_b_perf = wr_i
		& hit(addr_i, tuning_regs_pkg::CHAN_B_SPECIAL_PERF_OFS);
	assign wr_part3 = wr_i
		& hit(addr_i, tuning_regs_pkg::HIGH_IF_PART_THREE_OFS);
	assign wr_chopper = wr_i
		& hit(addr_i, tuning_regs_pkg::CHAN_C_CHOPPER_CTRL_OFS);
	assign wr_c_dither = wr_i
		& hit(addr_i, tuning_regs_pkg::CHAN_C_DITHER_CTRL_OFS);
	assign wr_c_perf = wr_i
		& hit(addr_i, tuning_regs_pkg::CHAN_C_SPECIAL_PERF_OFS);
	assign wr_upper = wr_i
		& hit(addr_i, tuning_regs_pkg::HIGH_IF_UPPER_PAIR_OFS);

	// ==========================================================
	// Storage

	// Only the read/write fields are kept; write-only bits never reach a flip-flop.
	// Masking on the way in means every readback shows zero in the write-only places.
	logic [7:0] chan_b_dither_ctrl_r;
	logic [7:0] chan_b_special_perf_r;
	logic [7:0] high_if_part_three_r;
	logic [7:0] chan_c_chopper_ctrl_r;
	logic [7:0] chan_c_dither_ctrl_r;
	logic [7:0] chan_c_special_perf_r;
	logic [7:0] high_if_upper_pair_r;
	logic [7:0] rdata_nxt;

	// Channel B dither pair.
	// Its companion pair lives outside this bank and is brought in as a level.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_b_dither_ctrl_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_b_dither)
		begin
			chan_b_dither_ctrl_r <= wdata_i & tuning_regs_pkg::DITHER_MASK;
		end
	end

	// Channel B best-performance bit.
	// It comes up clear, so the channel runs in the weaker mode until software sets it.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_b_special_perf_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_b_perf)
		begin
			chan_b_special_perf_r <= wdata_i & tuning_regs_pkg::BEST_PERF_MASK;
		end
	end

	// High-IF mode bit, part three.
	// It only helps above the high input frequency band and is left to software.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			high_if_part_three_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_part3)
		begin
			high_if_part_three_r <= wdata_i & tuning_regs_pkg::HIGH_IF3_MASK;
		end
	end

	// Channel C chopper control.
	// Clear keeps the chopper running, which moves low-frequency noise away from dc.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_c_chopper_ctrl_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_chopper)
		begin
			chan_c_chopper_ctrl_r <= wdata_i & tuning_regs_pkg::CHOPPER_MASK;
		end
	end

	// Channel C dither pair.
	// It is kept apart from channel B so one channel never changes the other.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_c_dither_ctrl_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_c_dither)
		begin
			chan_c_dither_ctrl_r <= wdata_i & tuning_regs_pkg::DITHER_MASK;
		end
	end

	// Channel C best-performance bit.
	// Like channel B, it must be written again after every reset.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_c_special_perf_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_c_perf)
		begin
			chan_c_special_perf_r <= wdata_i & tuning_regs_pkg::BEST_PERF_MASK;
		end
	end

	// Upper high-IF mode pair.
	// Both bits are stored together and leave the bank as one two-bit control.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			high_if_upper_pair_r <= tuning_regs_pkg::REG_RESET;
		end
		else if (wr_upper)
		begin
			high_if_upper_pair_r <= wdata_i & tuning_regs_pkg::HIGH_IF_UPPER_MASK;
		end
	end

	// ==========================================================
	// Read path

	// Selects read data; unmapped addresses read zero so software can probe the map safely.
	// A default value at the top keeps the process free of latches.
	always_comb
	begin
		rdata_nxt = tuning_regs_pkg::REG_RESET;
		case (addr_i)
			tuning_regs_pkg::CHAN_B_DITHER_CTRL_OFS:
				rdata_nxt = chan_b_dither_ctrl_r;
			tuning_regs_pkg::CHAN_B_SPECIAL_PERF_OFS:
				rdata_nxt = chan_b_special_perf_r;
			tuning_regs_pkg::HIGH_IF_PART_THREE_OFS:
				rdata_nxt = high_if_part_three_r;
			tuning_regs_pkg::CHAN_C_CHOPPER_CTRL_OFS:
				rdata_nxt = chan_c_chopper_ctrl_r;
			tuning_regs_pkg::CHAN_C_DITHER_CTRL_OFS:
				rdata_nxt = chan_c_dither_ctrl_r;
			tuning_regs_pkg::CHAN_C_SPECIAL_PERF_OFS:
				rdata_nxt = chan_c_special_perf_r;
			tuning_regs_pkg::HIGH_IF_UPPER_PAIR_OFS:
				rdata_nxt = high_if_upper_pair_r;
			default:
				rdata_nxt = tuning_regs_pkg::REG_RESET;
		endcase
	end

	// Read data stand for one cycle after the strobe and are zero otherwise.
	// Returning to zero between reads keeps a stale value from passing for a fresh one.
	// A read in the cycle after a write already sees the new contents.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rdata_o <= tuning_regs_pkg::REG_RESET;
		end
		else if (rd_i)
		begin
			rdata_o <= rdata_nxt;
		end
		else
		begin
			rdata_o <= tuning_regs_pkg::REG_RESET;
		end
	end

	// ==========================================================
	// Dither controls

	// Channel B dither turns off only with its own pair and its companion pair all set.
	// Any other mix keeps the default dithered operation.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_b_no_dither_o <= 1'b0;
		end
		else
		begin
			chan_b_no_dither_o <= pair_set(chan_b_dither_ctrl_r) & (&chan_b_companion_i);
		end
	end

	// Channel C dither follows the same rule with its own pair and its own companion pair.
	// The companion input is a level, so the control settles one cycle after it changes.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			chan_c_no_dither_o <= 1'b0;
		end
		else
		begin
			chan_c_no_dither_o <= pair_set(chan_c_dither_ctrl_r) & (&chan_c_companion_i);
		end
	end

	// ==========================================================
	// Mode controls

	// Mode bits drive the analog controls straight from their flip-flops.
	// Each one follows its register in the same cycle the write lands, with no added register stage.

	// Channel B best-performance mode.
	assign chan_b_best_perf_o = chan_b_special_perf_r[tuning_regs_pkg::BEST_PERF_BIT];

	// Channel C best-performance mode.
	assign chan_c_best_perf_o = chan_c_special_perf_r[tuning_regs_pkg::BEST_PERF_BIT];

	// Channel C chopper disable; high stops the chopper.
	assign chan_c_no_chopper_o = chan_c_chopper_ctrl_r[tuning_regs_pkg::CHOPPER_BIT];

	// High-IF mode, part three.
	assign high_freq_input_part3_o = high_if_part_three_r[tuning_regs_pkg::HIGH_IF3_BIT];

	// Upper high-IF mode pair, most significant bit first.
	assign high_freq_input_upper_o = high_if_upper_pair_r[tuning_regs_pkg::HIGH_IF_UPPER_HI_BIT:
		tuning_regs_pkg::HIGH_IF_UPPER_LO_BIT];

endmodule

// [sim/tuning_regs_props.sv]
`timescale 1ns/10ps
// ==========
// Port checker for the tuning register bank.
module tuning_regs_props (
	input logic sys_clk_i, // Clock.
	input logic rstn_i, // Reset, active low.
	input logic wr_i, // Write strobe.
	input logic rd_i, // Read strobe.
	input logic [11:0] addr_i, // Address.
	input logic [7:0] wdata_i, // Write data.
	input logic [7:0] rdata_o, // Read data.
	input logic [1:0] chan_b_companion_i, // Channel B companion pair.
	input logic [1:0] chan_c_companion_i, // Channel C companion pair.
	input logic [1:0] high_freq_input_upper_o, // Upper high-IF pair.
	input logic chan_b_no_dither_o, // Channel B dither off.
	input logic chan_c_no_dither_o, // Channel C dither off.
	input logic chan_b_best_perf_o, // Channel B mode.
	input logic chan_c_best_perf_o, // Channel C mode.
	input logic chan_c_no_chopper_o, // Chopper off.
	input logic high_freq_input_part3_o // High-IF part three.
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// A write strobe to one address.
	sequence wr_to(logic [11:0] a);
		wr_i && addr_i == a;
	endsequence
	rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero");
	b_perf_a: assert property (wr_to(12'h439) |=> chan_b_best_perf_o == $past(wdata_i[3]))
		else $error("channel b mode wrong");
	c_perf_a: assert property (wr_to(12'h539) |=> chan_c_best_perf_o == $past(wdata_i[3]))
		else $error("channel c mode wrong");
	chop_set_a: assert property (wr_to(12'h522) |=> chan_c_no_chopper_o == $past(wdata_i[1]))
		else $error("chopper bit wrong");
	part3_set_a: assert property (wr_to(12'h51d) |=> high_freq_input_part3_o == $past(wdata_i[1]))
		else $error("part three bit wrong");
	upper_set_a: assert property (wr_to(12'h608) |=> high_freq_input_upper_o == $past(wdata_i[7:6]))
		else $error("upper pair wrong");
	dith_b_a: assert property (chan_b_no_dither_o |-> $past(chan_b_companion_i) == 2'b11)
		else $error("channel b dither off early");
	dith_c_a: assert property (chan_c_no_dither_o |-> $past(chan_c_companion_i) == 2'b11)
		else $error("channel c dither off early");
endmodule
bind adc_channel_tuning_regs tuning_regs_props props_inst (.*);

// [sim/adc_channel_tuning_regs_tb.sv]
`timescale 1ns/10ps
// ==========
// Self-checking bench for the tuning register bank.
module adc_channel_tuning_regs_tb;
	logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic [1:0] comp_b = 2'b00, comp_c = 2'b00;
	wire [7:0] rdata, outs;
	int num_errors = 0, num_checks = 0;
	logic [11:0] ofs [7] = '{12'h434, 12'h439, 12'h51d, 12'h522, 12'h534, 12'h539, 12'h608};
	logic [7:0] msk [7] = '{8'h28, 8'h08, 8'h02, 8'h02, 8'h28, 8'h08, 8'hc0};
	// Clock of 50 ns period.
	always #25 clk = ~clk;
	adc_channel_tuning_regs adc_channel_tuning_regs_inst (.sys_clk_i(clk), .rstn_i(rstn), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .chan_b_companion_i(comp_b),
		.chan_c_companion_i(comp_c), .chan_b_no_dither_o(outs[7]), .chan_c_no_dither_o(outs[6]),
		.chan_b_best_perf_o(outs[5]), .chan_c_best_perf_o(outs[4]), .chan_c_no_chopper_o(outs[3]),
		.high_freq_input_part3_o(outs[2]), .high_freq_input_upper_o(outs[1:0]));
	// ==========
	// Bus cycles and comparison.
	task automatic cmp(input string what, input logic [7:0] exp, got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 cmp("rdata", exp, rdata);
	endtask
	// Lets the two-cycle dither path land.
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// ==========
	// Scenarios.
	task automatic t_reset;
		cmp("outs", 8'h00, outs);
		for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00);
		$display("test reset done");
	endtask
	// Every field set with write-only bits kept at zero; an unmapped place reads zero.
	task automatic t_access;
		for (int i = 0; i < 7; i++) wr(ofs[i], msk[i]);
		wr(12'h435, 8'hff);
		settle();
		cmp("outs", 8'h3f, outs);
		for (int i = 0; i < 7; i++) rd(ofs[i], msk[i]);
		rd(12'h435, 8'h00);
		for (int i = 0; i < 7; i++) wr(ofs[i], 8'h00);
		settle();
		cmp("outs", 8'h00, outs);
		$display("test access done");
	endtask
	// A reset in mid-run clears every field; both modes are then written again.
	task automatic t_rereset;
		wr(12'h439, 8'h08);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1 cmp("outs", 8'h00, outs);
		rd(12'h439, 8'h00);
		wr(12'h439, 8'h08);
		wr(12'h539, 8'h08);
		settle();
		cmp("outs", 8'h30, outs);
		$display("test reset again done");
	endtask
	// Every companion pair on both channels, then one own bit missing.
	task automatic t_dither;
		wr(12'h434, 8'h28);
		wr(12'h534, 8'h28);
		for (int v = 0; v < 16; v++)
		begin
			@(posedge clk);
			comp_b <= v[1:0];
			comp_c <= v[3:2];
			settle();
			cmp("dither", {v[1:0] == 2'b11, v[3:2] == 2'b11, 6'h00}, outs);
		end
		wr(12'h434, 8'h20);
		wr(12'h534, 8'h08);
		settle();
		cmp("dither", 8'h00, outs);
		$display("test dither done");
	endtask
	// Reset, the scenarios and the verdict.
	initial
	begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_access();
		t_dither();
		t_rereset();
		tally_and_finish();
	end
	// Watchdog.
	initial
	begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
endmodule
